// ### logic/plfc_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
module plfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk_in,
  input  wire             arst_n_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count
  assign wr_ready_out = (cnt_reg != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_reg != {(AW+1){1'b0}});
  assign rd_data_out  = mem_reg[rp_reg];
  assign push = wr_valid_in & wr_ready_out;
  assign pop  = rd_valid_out & rd_ready_in;

  // Storage array has no reset; only pointers and count need one
  always @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wp_reg] <= wr_data_in;
    end
  end

  // Pointer and count update
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ### logic/plfc_map.vh
// Constants for the point-to-point link frame controller
`ifndef PLFC_MAP_VH
`define PLFC_MAP_VH
`define PLFC_CH_DLE      8'h10
`define PLFC_CH_SOH      8'h01
`define PLFC_CH_STX      8'h02
`define PLFC_CH_ETX      8'h03
`define PLFC_CH_ENQ      8'h05
`define PLFC_CH_NAK      8'h15
`define PLFC_CH_WACK     8'h3f
`define PLFC_CH_EVEN     8'h30
`define PLFC_CH_ODD      8'h31
`define PLFC_CH_PAD      8'hff
`define PLFC_BCAST_NODE  8'he9
`define PLFC_BUF_BYTES   295
`define PLFC_BIT_NS      8680
`define PLFC_CLK_NS      8
`define PLFC_CHAR_BITS   11
`define PLFC_GAP_CHARS   10
`define PLFC_PAD_COUNT   10
`define PLFC_RETRY_MAX   4'h3
`define PLFC_FIFO_DEPTH  16
`endif

// ### logic/plfc_top.v
// Data-link frame control for a point-to-point framed serial link
// Operation
// - A negative acknowledgment makes the sender resend the same frame.
// - Before a NAK resend, send 10 pads and wait 10 character times.
// - Route end node above 233 is broadcast; no reply past gateway modules.
// - On a direct link a broadcast command is still answered.
// - Master flips its tag after each acknowledged frame, keeps it on resend.
// - Slave does not check that the master toggles its tag.
// - Tags are per station; an acknowledgment echoes the answered frame tag.
// - A tag other than even or odd inside a frame draws a NAK.
// - Bytes from the frame opener through the checksum are inside a frame.
// - Inside a frame, DLE before an illegal value draws a NAK.
// - DLE ETX is legal only after DLE STX in the same frame.
// - DLE ENQ inside a frame is always illegal and draws a NAK.
// - Outside a frame, DLE SOH opens a new frame.
// - Outside a frame, ACK, NAK, busy or inquiry start their action.
// - Outside a frame, anything else is ignored.
// - After busy, resend a frame, starting 10 character times later.
// - Never answer an inquiry with busy.
// - Replies leave in command order, separately for priority and not.
// - A change of the busy count clears the NAK retry counter.
// - Keep resources to accept a reply even while answering busy.
// - A frame longer than the longest message draws a busy response.
// - Inline replies act at once; the frame buffer holds 295 bytes.
// - At power-up record NAK as last response and establish the link.
// - First tag is even after odd ack, odd after even ack or NAK.
// - A character time is one full character with start, parity, stop.
// - Each serial character is an 11-bit word.
`include "plfc_map.vh"
module plfc_top #(
  parameter [3:0] RETRY_MAX = `PLFC_RETRY_MAX
) (
  input  wire       core_clk_in,
  input  wire       arst_n_in,
  input  wire [7:0] rx_byte_in,
  input  wire       rx_valid_in,
  input  wire       direct_link_in,
  input  wire       tx_start_in,
  input  wire       tx_done_in,
  input  wire       busy_cnt_chg_in,
  input  wire       local_busy_in,
  input  wire       rx_is_reply_in,
  input  wire       rx_prio_in,
  input  wire [7:0] route_last_in,
  input  wire       cmd_done_in,
  input  wire       cmd_done_prio_in,
  output wire       rx_ready_out,
  output reg  [7:0] frm_byte_out,
  output reg        frm_valid_out,
  input  wire       frm_ready_in,
  output reg        frm_end_out,
  output reg  [7:0] resp_byte_out,
  output reg        resp_valid_out,
  input  wire       resp_ready_in,
  output reg        tag_odd_out,
  output reg        link_up_out,
  output reg        resend_out,
  output reg        pad_req_out,
  output reg        tx_hold_out,
  output reg        tx_ok_out,
  output reg        link_err_out,
  output reg        need_reply_out,
  output reg        reply_ok_out,
  output reg        reply_prio_out,
  output reg  [3:0] retry_cnt_out
);
  localparam CHAR_CYC = (`PLFC_CHAR_BITS * `PLFC_BIT_NS
                         + `PLFC_CLK_NS - 1) / `PLFC_CLK_NS;
  localparam GAP_CYC  = CHAR_CYC * `PLFC_GAP_CHARS;
  localparam [20:0] GAP_W = GAP_CYC;
  localparam [8:0]  BUF_MAX = `PLFC_BUF_BYTES;
  localparam [3:0]  PAD_N   = `PLFC_PAD_COUNT;
  localparam [1:0] S_OUT = 2'h0;
  localparam [1:0] S_IN  = 2'h1;
  localparam [1:0] S_ESC = 2'h2;
  localparam [1:0] S_OE  = 2'h3;
  localparam [1:0] R_NONE = 2'h0;
  localparam [1:0] R_ACK  = 2'h1;
  localparam [1:0] R_NAK  = 2'h2;
  localparam [1:0] R_BSY  = 2'h3;

  reg  [7:0]  rx_s1_reg;
  reg  [7:0]  rx_s2_reg;
  reg         rv_s1_reg;
  reg         rv_s2_reg;
  reg         rv_d_reg;
  reg  [1:0]  st_reg;
  reg         stx_seen_reg;
  reg         tag_seen_reg;
  reg         frm_tag_reg;
  reg         bad_reg;
  reg  [8:0]  len_reg;
  reg         ovf_reg;
  reg  [1:0]  last_resp_reg;
  reg         pend_reg;
  reg  [20:0] gap_reg;
  reg  [3:0]  pad_reg;
  reg         busy_chg_d_reg;
  reg  [3:0]  prio_q_reg;
  reg  [3:0]  norm_q_reg;
  wire        rx_new;
  wire [7:0]  rb;
  wire        fifo_ready;
  wire [7:0]  fifo_byte;
  wire        fifo_valid;
  wire        crc_last;

  // Pin-side byte and strobe go through two flops before any logic
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_s1_reg <= 8'h00;
      rx_s2_reg <= 8'h00;
      rv_s1_reg <= 1'b0;
      rv_s2_reg <= 1'b0;
      rv_d_reg  <= 1'b0;
    end else begin
      rx_s1_reg <= rx_byte_in;
      rx_s2_reg <= rx_s1_reg;
      rv_s1_reg <= rx_valid_in;
      rv_s2_reg <= rv_s1_reg;
      rv_d_reg  <= rv_s2_reg;
    end
  end
  // Strobe edge; byte must stay stable two cycles around its strobe
  assign rx_new = rv_s2_reg & ~rv_d_reg;
  assign rb = rx_s2_reg;
  assign rx_ready_out = 1'b1;
  // Byte after DLE ETX is the checksum, last byte inside the frame
  assign crc_last = (st_reg == S_OE);

  // Frame payload FIFO; a stalled drain that fills it marks the frame overflowed
  plfc_fifo #(
    .WIDTH (8),
    .DEPTH (`PLFC_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .wr_data_in   (rb),
    .wr_valid_in  (rx_new & (st_reg == S_IN) & (rb != `PLFC_CH_DLE)
                   & ~ovf_reg & ~bad_reg),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (fifo_byte),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (frm_ready_in | ~frm_valid_out)
  );

  // Output stage registers the FIFO head
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frm_byte_out  <= 8'h00;
      frm_valid_out <= 1'b0;
    end else if (frm_ready_in | ~frm_valid_out) begin
      frm_byte_out  <= fifo_byte;
      frm_valid_out <= fifo_valid;
    end
  end

  // Receive parser; slave side never checks the tag toggle
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg        <= S_OUT;
      stx_seen_reg  <= 1'b0;
      tag_seen_reg  <= 1'b0;
      frm_tag_reg   <= 1'b0;
      bad_reg       <= 1'b0;
      len_reg       <= 9'h000;
      ovf_reg       <= 1'b0;
      frm_end_out   <= 1'b0;
      resp_byte_out <= 8'h00;
      resp_valid_out <= 1'b0;
      last_resp_reg <= R_NAK;
      pend_reg      <= 1'b0;
      tx_ok_out     <= 1'b0;
      resend_out    <= 1'b0;
      link_err_out  <= 1'b0;
      tag_odd_out   <= 1'b1;
      link_up_out   <= 1'b0;
      retry_cnt_out <= 4'h0;
      gap_reg       <= 21'h000000;
      pad_reg       <= 4'h0;
      tx_hold_out   <= 1'b0;
      pad_req_out   <= 1'b0;
      busy_chg_d_reg <= 1'b0;
    end else begin
      frm_end_out  <= 1'b0;
      tx_ok_out    <= 1'b0;
      resend_out   <= 1'b0;
      link_err_out <= 1'b0;
      pad_req_out  <= 1'b0;
      busy_chg_d_reg <= busy_cnt_chg_in;
      if (resp_valid_out & resp_ready_in) begin
        resp_valid_out <= 1'b0;
      end
      if (tx_start_in) begin
        pend_reg <= 1'b1;
      end
      if (busy_cnt_chg_in & ~busy_chg_d_reg) begin
        retry_cnt_out <= 4'h0;
      end
      if (pad_reg != 4'h0) begin
        pad_reg     <= pad_reg - 4'h1;
        pad_req_out <= 1'b1;
      end else if (gap_reg != 21'h000000) begin
        gap_reg <= gap_reg - 21'h000001;
        if (gap_reg == 21'h000001) begin
          tx_hold_out <= 1'b0;
          resend_out  <= 1'b1;
        end
      end
      if (rx_new) begin
        case (st_reg)
          S_OUT: begin
            if (stx_seen_reg) begin
              stx_seen_reg <= 1'b0;
              if (rb == `PLFC_CH_SOH) begin
                st_reg <= S_IN;
                tag_seen_reg <= 1'b0;
                bad_reg <= 1'b0;
                len_reg <= 9'h000;
                ovf_reg <= 1'b0;
              end else if (pend_reg & (rb == `PLFC_CH_EVEN
                                       | rb == `PLFC_CH_ODD)) begin
                pend_reg <= 1'b0;
                retry_cnt_out <= 4'h0;
                tx_ok_out <= 1'b1;
                if (!link_up_out) begin
                  link_up_out <= 1'b1;
                  tag_odd_out <= (rb == `PLFC_CH_EVEN);
                end else begin
                  tag_odd_out <= ~tag_odd_out;
                end
              end else if (pend_reg & (rb == `PLFC_CH_NAK)) begin
                if (!link_up_out) begin
                  link_up_out <= 1'b1;
                  tag_odd_out <= 1'b1;
                  pend_reg <= 1'b0;
                  tx_ok_out <= 1'b1;
                end else if (retry_cnt_out >= RETRY_MAX) begin
                  pend_reg <= 1'b0;
                  link_err_out <= 1'b1;
                  retry_cnt_out <= 4'h0;
                end else begin
                  retry_cnt_out <= retry_cnt_out + 4'h1;
                  pad_reg <= PAD_N;
                  gap_reg <= GAP_W;
                  tx_hold_out <= 1'b1;
                end
              end else if (pend_reg & (rb == `PLFC_CH_WACK)) begin
                gap_reg <= GAP_W;
                tx_hold_out <= 1'b1;
              // inquiry repeats last ACK, otherwise NAK; never busy
              end else if (rb == `PLFC_CH_ENQ) begin
                resp_byte_out <= (last_resp_reg == R_ACK) ?
                  (frm_tag_reg ? `PLFC_CH_ODD : `PLFC_CH_EVEN) :
                  `PLFC_CH_NAK;
                resp_valid_out <= 1'b1;
              end
            end else if (rb == `PLFC_CH_DLE) begin
              stx_seen_reg <= 1'b1;
            end
          end
          S_IN: begin
            if (len_reg == BUF_MAX) begin
              ovf_reg <= 1'b1;
            end else if (rb != `PLFC_CH_DLE) begin
              len_reg <= len_reg + 9'h001;
            end
            if (!fifo_ready) begin
              ovf_reg <= 1'b1;
            end
            if (rb == `PLFC_CH_DLE) begin
              st_reg <= S_ESC;
            end else if (!tag_seen_reg) begin
              tag_seen_reg <= 1'b1;
              frm_tag_reg <= rb[0];
              // tag must be even or odd
              if (rb != `PLFC_CH_EVEN && rb != `PLFC_CH_ODD) begin
                bad_reg <= 1'b1;
              end
            end
          end
          S_ESC: begin
            st_reg <= S_IN;
            // legal escapes only; ENQ never legal
            if (rb == `PLFC_CH_STX) begin
              stx_seen_reg <= 1'b1;
            // ETX needs STX first; checksum still closes the frame
            end else if (rb == `PLFC_CH_ETX) begin
              st_reg <= S_OE;
              if (!stx_seen_reg) begin
                bad_reg <= 1'b1;
              end
            // inline reply acted on, not stored
            end else if (pend_reg & (rb == `PLFC_CH_EVEN
                                     | rb == `PLFC_CH_ODD)) begin
              pend_reg <= 1'b0;
              tx_ok_out <= 1'b1;
              tag_odd_out <= ~tag_odd_out;
            end else if (rb != `PLFC_CH_DLE) begin
              bad_reg <= 1'b1;
            end
          end
          default: begin
            st_reg <= S_OUT;
            stx_seen_reg <= 1'b0;
            frm_end_out <= 1'b1;
            resp_valid_out <= 1'b1;
            // replies accepted while busy to commands
            if (bad_reg) begin
              resp_byte_out <= `PLFC_CH_NAK;
              last_resp_reg <= R_NAK;
            end else if (ovf_reg | (local_busy_in & ~rx_is_reply_in)) begin
              resp_byte_out <= `PLFC_CH_WACK;
              last_resp_reg <= R_BSY;
            end else begin
              resp_byte_out <= frm_tag_reg ? `PLFC_CH_ODD : `PLFC_CH_EVEN;
              last_resp_reg <= R_ACK;
            end
          end
        endcase
        if (crc_last) begin
          stx_seen_reg <= 1'b0;
        end
      end
    end
  end

  // Reply ordering tracks outstanding priority and normal commands
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prio_q_reg     <= 4'h0;
      norm_q_reg     <= 4'h0;
      need_reply_out <= 1'b0;
      reply_ok_out   <= 1'b0;
      reply_prio_out <= 1'b0;
    end else begin
      need_reply_out <= 1'b0;
      reply_ok_out   <= 1'b0;
      if (frm_end_out & (last_resp_reg == R_ACK) & ~rx_is_reply_in) begin
        // broadcast suppressed; direct link still answers
        need_reply_out <= direct_link_in
                          | (route_last_in <= `PLFC_BCAST_NODE);
        reply_prio_out <= rx_prio_in;
        if (rx_prio_in) begin
          prio_q_reg <= prio_q_reg + 4'h1;
        end else begin
          norm_q_reg <= norm_q_reg + 4'h1;
        end
      // replies released in arrival order per class
      end else if (cmd_done_in) begin
        if (cmd_done_prio_in & (prio_q_reg != 4'h0)) begin
          prio_q_reg   <= prio_q_reg - 4'h1;
          reply_ok_out <= 1'b1;
        end else if (~cmd_done_prio_in & (norm_q_reg != 4'h0)) begin
          norm_q_reg   <= norm_q_reg - 4'h1;
          reply_ok_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ### test/plfc_peer.sv
// Peer station model feeding the receive byte stream
module plfc_peer (
  input  wire logic       core_clk_in,
  input  wire logic       stall_in,
  output logic      [7:0] byte_out,
  output logic            valid_out,
  output logic            resp_ready_out,
  output logic            frm_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Payload sink stalls only when told to
  assign frm_ready_out = !stall_in;
  initial begin
    byte_out = 8'h00;
    valid_out = 1'b0;
    resp_ready_out = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(negedge core_clk_in);
    byte_out = b;
    valid_out = 1'b1;
    repeat (2) @(negedge core_clk_in);
    valid_out = 1'b0;
    @(negedge core_clk_in);
    byte_out = ~b; // Released line must not show a stale byte
    repeat (2) @(negedge core_clk_in);
  endtask
  // control pair: DLE, then the given control byte
  task automatic ctl(input logic [7:0] b);
    send(`PLFC_CH_DLE);
    send(b);
  endtask
  // Accept one response; ready held over exactly one sampling edge
  task automatic ack_resp();
    @(negedge core_clk_in);
    resp_ready_out = 1'b1;
    @(negedge core_clk_in);
    resp_ready_out = 1'b0;
  endtask
endmodule

// ### test/plfc_top_asserts.sv
// Concurrent checks on the link frame controller ports
`include "plfc_map.vh"
module plfc_top_asserts #(
  parameter [3:0] RETRY_MAX = `PLFC_RETRY_MAX
) (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic       rx_valid_in,
  input wire logic       busy_cnt_chg_in,
  input wire logic       frm_ready_in,
  input wire logic       resp_ready_in,
  input wire logic       rx_ready_out,
  input wire logic [7:0] frm_byte_out,
  input wire logic       frm_valid_out,
  input wire logic       frm_end_out,
  input wire logic [7:0] resp_byte_out,
  input wire logic       resp_valid_out,
  input wire logic       tag_odd_out,
  input wire logic       link_up_out,
  input wire logic       pad_req_out,
  input wire logic       tx_ok_out,
  input wire logic [3:0] retry_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       vld_d;
  logic [7:0] prev_b;
  logic       enq_reg;
  logic [4:0] pad_len;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Watch raw strobes: inquiry flag lives until its answer is taken
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vld_d <= 1'b0;
      prev_b <= 8'h00;
      enq_reg <= 1'b0;
      pad_len <= 5'h00;
    end else begin
      vld_d <= rx_valid_in;
      pad_len <= pad_req_out ? pad_len + 5'h01 : 5'h00;
      if (rx_valid_in && !vld_d)
        prev_b <= rx_byte_in;
      if (rx_valid_in && !vld_d && prev_b == `PLFC_CH_DLE &&
          rx_byte_in == `PLFC_CH_ENQ)
        enq_reg <= 1'b1;
      else if ($fell(resp_valid_out))
        enq_reg <= 1'b0;
    end
  end
  sequence cleared_s;
    ##[1:8] (retry_cnt_out == 4'h0);
  endsequence
  sequence held_s;
    resp_valid_out && $stable(resp_byte_out);
  endsequence
  pad_ten_a: assert property (
    $fell(pad_req_out) |-> pad_len == 5'h0a) else $error("pad run length");
  rx_take_a: assert property (
    rx_ready_out) else $error("receive path refused");
  busy_clr_a: assert property (
    $rose(busy_cnt_chg_in) |-> cleared_s) else $error("retry not cleared");
  enq_busy_a: assert property (
    resp_valid_out && enq_reg |-> resp_byte_out != `PLFC_CH_WACK)
    else $error("inquiry answered busy");
  resp_hold_a: assert property (
    resp_valid_out && !resp_ready_in |=> held_s) else $error("resp dropped");
  frm_hold_a: assert property (
    frm_valid_out && !frm_ready_in |=> frm_valid_out && $stable(frm_byte_out))
    else $error("payload dropped");
  frm_end_a: assert property (
    frm_end_out |-> resp_valid_out) else $error("frame end without answer");
  tag_flip_a: assert property (
    $changed(tag_odd_out) && $past(link_up_out, 3) |->
    tx_ok_out || $past(tx_ok_out)) else $error("tag moved without ack");
  retry_max_a: assert property (
    retry_cnt_out <= RETRY_MAX) else $error("retry count past limit");
endmodule
bind plfc_top plfc_top_asserts #(.RETRY_MAX(RETRY_MAX)) plfc_top_asserts_i (
  .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .rx_byte_in(rx_byte_in),
  .rx_valid_in(rx_valid_in), .busy_cnt_chg_in(busy_cnt_chg_in),
  .frm_ready_in(frm_ready_in), .resp_ready_in(resp_ready_in),
  .rx_ready_out(rx_ready_out), .frm_byte_out(frm_byte_out),
  .frm_valid_out(frm_valid_out), .frm_end_out(frm_end_out),
  .resp_byte_out(resp_byte_out), .resp_valid_out(resp_valid_out),
  .tag_odd_out(tag_odd_out), .link_up_out(link_up_out),
  .pad_req_out(pad_req_out), .tx_ok_out(tx_ok_out),
  .retry_cnt_out(retry_cnt_out));

// ### test/tb_plfc_top.sv
// Self-checking bench for the link frame controller
`include "plfc_map.vh"
module tb_plfc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_in;
  logic       arst_n_in;
  logic [7:0] rx_byte_in;
  logic       rx_valid_in;
  logic       direct_link_in;
  logic       tx_start_in;
  logic       busy_cnt_chg_in;
  logic [7:0] route_last_in;
  logic       cmd_done_in;
  logic       cmd_done_prio_in;
  logic       local_busy_in;
  logic       rx_is_reply_in;
  logic       rx_prio_in;
  logic       frm_end_out;
  logic       resend_out;
  logic       link_err_out;
  logic       reply_ok_out;
  logic       reply_prio_out;
  logic       frm_ready_in;
  logic       resp_ready_in;
  logic       stall;
  logic [7:0] frm_byte_out;
  logic       frm_valid_out;
  logic [7:0] resp_byte_out;
  logic       resp_valid_out;
  logic       tag_odd_out;
  logic       link_up_out;
  logic       pad_req_out;
  logic       tx_hold_out;
  logic       tx_ok_out;
  logic       need_reply_out;
  logic [3:0] retry_cnt_out;
  int         n_mismatch;
  int         checks_done;
  int         n_reply;
  int         n_ok;
  int         n_pad;
  int         n_end;
  int         n_err;
  int         n_rok;
  logic [7:0] frm_q[$];
  plfc_top plfc_top_i (.core_clk_in, .arst_n_in, .rx_byte_in, .rx_valid_in,
    .direct_link_in, .tx_start_in, .tx_done_in(1'b0), .busy_cnt_chg_in,
    .local_busy_in, .rx_is_reply_in, .rx_prio_in,
    .route_last_in, .cmd_done_in, .cmd_done_prio_in, .rx_ready_out(),
    .frm_byte_out, .frm_valid_out, .frm_ready_in, .frm_end_out,
    .resp_byte_out, .resp_valid_out, .resp_ready_in, .tag_odd_out,
    .link_up_out, .resend_out, .pad_req_out, .tx_hold_out, .tx_ok_out,
    .link_err_out, .need_reply_out, .reply_ok_out, .reply_prio_out,
    .retry_cnt_out);
  plfc_peer plfc_peer_i (.core_clk_in, .stall_in(stall),
    .byte_out(rx_byte_in), .valid_out(rx_valid_in),
    .resp_ready_out(resp_ready_in), .frm_ready_out(frm_ready_in));
  // Free-running 125 MHz clock
  always #4 core_clk_in = ~core_clk_in;
  // Collect payload and count single-cycle events
  always @(posedge core_clk_in) begin
    if (frm_valid_out === 1'b1 && frm_ready_in === 1'b1)
      frm_q.push_back(frm_byte_out);
    if (need_reply_out === 1'b1) n_reply++;
    if (tx_ok_out === 1'b1) n_ok++;
    if (pad_req_out === 1'b1) n_pad++;
    if (frm_end_out === 1'b1) n_end++;
    if (link_err_out === 1'b1) n_err++;
    if (reply_ok_out === 1'b1) n_rok++;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Wait bounded for a response, compare it, then take it
  task get_resp(input logic [7:0] e);
    for (int i = 0; i < 4000 && resp_valid_out !== 1'b1; i++)
      @(negedge core_clk_in);
    if (resp_valid_out !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no response", $time);
      conclude();
    end else begin
      chk(resp_byte_out, e);
      plfc_peer_i.ack_resp();
    end
  endtask
  // One command-finished strobe, then time for the release pulse
  task cmd_pulse(input logic p);
    cmd_done_prio_in = p;
    cmd_done_in = 1'b1;
    @(negedge core_clk_in);
    cmd_done_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
  endtask
  task pulse_start();
    @(negedge core_clk_in);
    tx_start_in = 1'b1;
    @(negedge core_clk_in);
    tx_start_in = 1'b0;
  endtask
  // Kind 0 well formed, 1 lacks the text start, 2 has an inquiry inside
  task frame(input logic [7:0] tag, input int n, input int kind);
    plfc_peer_i.ctl(`PLFC_CH_SOH);
    plfc_peer_i.send(tag);
    plfc_peer_i.send(8'h30);
    plfc_peer_i.send(8'h35);
    if (kind != 1) plfc_peer_i.ctl(`PLFC_CH_STX);
    for (int i = 0; i < n; i++) plfc_peer_i.send(8'h41 + 8'(i % 64));
    if (kind == 2) plfc_peer_i.ctl(`PLFC_CH_ENQ);
    plfc_peer_i.ctl(`PLFC_CH_ETX);
    plfc_peer_i.send(8'h5a);
  endtask
  task t_establish();
    chk({7'h00, tag_odd_out}, 8'h01);
    plfc_peer_i.ctl(`PLFC_CH_ENQ);
    get_resp(`PLFC_CH_NAK);
    pulse_start();
    plfc_peer_i.ctl(`PLFC_CH_ODD);
    repeat (10) @(negedge core_clk_in);
    chk({6'h00, link_up_out, tag_odd_out}, 8'h02);
  endtask
  task t_ack();
    int k;
    k = n_ok;
    pulse_start();
    plfc_peer_i.ctl(`PLFC_CH_EVEN);
    repeat (10) @(negedge core_clk_in);
    chk({7'h00, tag_odd_out}, 8'h01);
    chk(8'(n_ok - k), 8'h01);
  endtask
  // payload kept across a stalled stream
  task t_stall();
    int j;
    j = 0;
    frm_q.delete();
    stall = 1'b1;
    frame(`PLFC_CH_ODD, 10, 0);
    get_resp(`PLFC_CH_ODD);
    stall = 1'b0;
    repeat (40) @(negedge core_clk_in);
    foreach (frm_q[k])
      if (j < 10 && frm_q[k] == 8'h41 + 8'(j)) j++;
    chk(8'(j), 8'h0a);
  endtask
  // malformed frames draw a negative answer
  task t_illegal();
    logic [7:0] tg [3] = '{8'h37, `PLFC_CH_EVEN, `PLFC_CH_EVEN};
    for (int k = 0; k < 3; k++) begin
      frame(tg[k], 2, k);
      get_resp(`PLFC_CH_NAK);
    end
  endtask
  // stray bytes ignored, inquiry repeats the last answer
  task t_outside();
    int c;
    c = 0;
    plfc_peer_i.send(8'h41);
    plfc_peer_i.ctl(8'h42);
    repeat (60) @(negedge core_clk_in)
      if (resp_valid_out !== 1'b0) c++;
    chk(8'(c), 8'h00);
    plfc_peer_i.ctl(`PLFC_CH_ENQ);
    get_resp(`PLFC_CH_NAK);
  endtask
  // broadcast command answered only on a direct link
  task t_bcast();
    logic [9:0] cs [3] = '{10'h2e9, 10'h0ea, 10'h3ea};
    int q;
    for (int k = 0; k < 3; k++) begin
      int r;
      logic [7:0] t;
      r = n_reply;
      t = k[0] ? `PLFC_CH_ODD : `PLFC_CH_EVEN;
      {direct_link_in, route_last_in} = cs[k][8:0];
      rx_prio_in = (k == 2);
      frame(t, 2, 0);
      get_resp(t);
      repeat (20) @(negedge core_clk_in);
      chk(8'(n_reply - r), {7'h00, cs[k][9]});
      chk({7'h00, reply_prio_out}, 8'(k == 2));
      q = n_rok;
      cmd_pulse(rx_prio_in);
      chk(8'(n_rok - q), 8'h01);
    end
    rx_prio_in = 1'b0;
    q = n_rok;
    cmd_pulse(1'b1);
    chk(8'(n_rok - q), 8'h00);
  endtask
  task t_overflow();
    int r;
    int e;
    r = n_reply;
    e = n_end;
    frame(`PLFC_CH_ODD, 300, 0);
    get_resp(`PLFC_CH_WACK);
    local_busy_in = 1'b1;
    frame(`PLFC_CH_EVEN, 2, 0);
    get_resp(`PLFC_CH_WACK);
    rx_is_reply_in = 1'b1;
    frame(`PLFC_CH_ODD, 2, 0);
    get_resp(`PLFC_CH_ODD);
    repeat (4) @(negedge core_clk_in);
    local_busy_in = 1'b0;
    rx_is_reply_in = 1'b0;
    chk(8'(n_reply - r), 8'h00);
    chk(8'(n_end - e), 8'h03);
  endtask
  // negative answer starts pads and gap, keeps the tag
  task t_nak();
    int p;
    logic t;
    p = n_pad;
    t = tag_odd_out;
    pulse_start();
    plfc_peer_i.ctl(`PLFC_CH_NAK);
    repeat (50) @(negedge core_clk_in);
    chk(8'(n_pad - p), 8'h0a);
    chk({2'h0, resend_out, tx_hold_out, retry_cnt_out}, 8'h11);
    chk({7'h00, tag_odd_out}, {7'h00, t});
    busy_cnt_chg_in = 1'b1;
    repeat (10) @(negedge core_clk_in);
    chk({4'h0, retry_cnt_out}, 8'h00);
    busy_cnt_chg_in = 1'b0;
    p = n_err;
    repeat (4) plfc_peer_i.ctl(`PLFC_CH_NAK);
    repeat (4) @(negedge core_clk_in);
    chk(8'(n_err - p), 8'h01);
  endtask
  // Reset for 12 cycles, then run every scenario
  initial begin
    core_clk_in = 1'b0;
    arst_n_in = 1'b0;
    direct_link_in = 1'b1;
    tx_start_in = 1'b0;
    busy_cnt_chg_in = 1'b0;
    route_last_in = 8'h05;
    cmd_done_in = 1'b0;
    cmd_done_prio_in = 1'b0;
    local_busy_in = 1'b0;
    rx_is_reply_in = 1'b0;
    rx_prio_in = 1'b0;
    stall = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    n_reply = 0;
    n_ok = 0;
    n_pad = 0;
    repeat (12) @(posedge core_clk_in);
    @(negedge core_clk_in);
    arst_n_in = 1'b1;
    t_establish();
    t_ack();
    t_stall();
    t_illegal();
    t_outside();
    t_bcast();
    t_overflow();
    t_nak();
    conclude();
  end
endmodule
